// [hdl/hcw_pkg.sv]
// Purpose: constants and types shared by the hop control word generator
// Assumes: 28-bit clocks, 48-bit device address
// Notes:   positions are bit indices into the clock vectors
package hcw_pkg;
	localparam int HCW_CLK_W       = 28;
	localparam int HCW_ADDR_W      = 48;
	localparam int HCW_LAP_W       = 24;
	localparam logic [4:0] HCW_KOFF_A    = 5'h18; // first train offset 24
	localparam logic [4:0] HCW_KOFF_B    = 5'h08; // second train offset 8
	localparam logic [4:0] HCW_KOFF_STEP = 5'h10; // train switch step 16
	localparam logic [3:0] HCW_OFF23     = 4'h8;  // 23-hop page offset
	localparam logic [6:0] HCW_MOD79     = 7'h4f;
	localparam logic [6:0] HCW_MOD23     = 7'h17;
	localparam logic [5:0] HCW_Y2_79     = 6'h20; // 32 x bit 1
	localparam logic [5:0] HCW_Y2_23     = 6'h10; // 16 x bit 1
	localparam logic [4:0] HCW_N_ONE     = 5'h01; // master response count start
	localparam logic [3:0] HCW_DCI_RST   = 4'h0;  // class indicator nibble reset

	typedef enum logic [2:0] {
		HCW_PSCAN = 3'b000,
		HCW_ISCAN = 3'b001,
		HCW_PAGE  = 3'b010,
		HCW_INQ   = 3'b011,
		HCW_SRSP  = 3'b100,
		HCW_MRSP  = 3'b101,
		HCW_IRSP  = 3'b110,
		HCW_CONN  = 3'b111
	} hcw_state_e;
endpackage

// [hdl/hcw_mod_if.sv]
// Purpose: carries a wide value and its reduced result between modules
// Assumes: combinational reduction
// Notes:   used for the F offsets
`timescale 1ns/1ns
`default_nettype none
interface hcw_mod_if;
	logic [26:0] value;
	logic [6:0]  result;
	modport user (output value, input result);
	modport unit (input value, output result);
endinterface
`default_nettype wire

// [hdl/hcw_mod_reduce.sv]
// Purpose: remainder of a value by a fixed small modulus
// Assumes: modulus below 128
// Notes:   combinational; synthesises to a divider-free constant remainder
`timescale 1ns/1ns
`default_nettype none
module hcw_mod_reduce #(
	parameter logic [6:0] MODULUS = 7'h4f
) (
	hcw_mod_if.unit port
);
	import hcw_pkg::*;
	// constant-modulus remainder, tool folds it into logic
	always_comb
	begin
		port.result = 7'((port.value % 27'(MODULUS)));
	end
endmodule
`default_nettype wire

// [hdl/hcw_gen.sv]
// Purpose: forms the hop kernel control inputs X, Y1, Y2, A-F per state
// Assumes: clocks advance synchronously; events are one-cycle pulses
// Notes:   outputs are registered; values follow clock, state and address changes a cycle later, event changes two cycles later
`timescale 1ns/1ns
`default_nettype none
module hcw_gen (
	input  wire  logic                              clock,
	input  wire  logic                              sys_rst,
	input  wire  hcw_pkg::hcw_state_e               linkState,
	input  wire  logic                              hop23,
	input  wire  logic [hcw_pkg::HCW_CLK_W-1:0]     nativeClock,
	input  wire  logic [hcw_pkg::HCW_CLK_W-1:0]     peerClockEstimate,
	input  wire  logic [hcw_pkg::HCW_CLK_W-1:0]     masterClock,
	input  wire  logic [hcw_pkg::HCW_ADDR_W-1:0]    ownAddress,
	input  wire  logic [hcw_pkg::HCW_ADDR_W-1:0]    masterAddress,
	input  wire  logic [hcw_pkg::HCW_LAP_W-1:0]     generalInquiryCode,
	input  wire  logic [3:0]                        defaultClassIndicator,
	input  wire  logic                              trainSwitch,
	input  wire  logic                              ownCodeSeen,
	input  wire  logic                              pageAck,
	input  wire  logic                              slaveIdSeen,
	input  wire  logic                              syncInfoSent,
	output logic [4:0]                              hopX,
	output logic                                    hopY1,
	output logic [5:0]                              hopY2,
	output logic [4:0]                              hopA,
	output logic [3:0]                              hopB,
	output logic [4:0]                              hopC,
	output logic [8:0]                              hopD,
	output logic [6:0]                              hopE,
	output logic [6:0]                              hopF
);
	import hcw_pkg::*;

	logic [4:0]  koff_reg, koff_next;
	logic [4:0]  frzKoff_reg, frzKoff_next;
	logic [4:0]  frzNat_reg, frzNat_next;
	logic [27:0] frzEst_reg, frzEst_next;
	logic [4:0]  cntN_reg, cntN_next;
	logic        natB1_reg, natB1_next, estB1_reg, estB1_next;
	logic [4:0]  x_next, a_next, c_next;
	logic        y1_next;
	logic [5:0]  y2_next;
	logic [3:0]  b_next;
	logic [8:0]  d_next;
	logic [6:0]  e_next, f_next;
	logic [27:0] addr;
	logic [27:0] clkSel;
	logic        natFall, estFall;
	logic [6:0]  f79, f23;

	hcw_mod_if m79 ();
	hcw_mod_if m23 ();
	hcw_mod_reduce #(.MODULUS(HCW_MOD79)) uMod79 (.port(m79.unit));
	hcw_mod_reduce #(.MODULUS(HCW_MOD23)) uMod23 (.port(m23.unit));

	// F offsets are only meaningful in connection
	assign m79.value = 27'({masterClock[27:7], 4'h0});
	assign m23.value = 27'({masterClock[27:6], 3'h0});
	assign f79       = m79.result;
	assign f23       = m23.result;

	// falling edges of bit 1 mark the start of a master transmit slot
	assign natFall = natB1_reg & ~nativeClock[1];
	assign estFall = estB1_reg & ~peerClockEstimate[1];

	// page formula, shared by page, inquiry and master response
	function automatic logic [4:0] page_x(
		input logic [27:0] c,
		input logic [4:0]  ko,
		input logic        h23
	);
		logic [3:0] diff;
		logic [3:0] lo;
		lo   = {c[4:2], c[0]};
		diff = lo - c[15:12];
		if (h23)
			page_x = {1'b0, c[15:12] + HCW_OFF23 + lo};
		else
			page_x = c[16:12] + ko + {1'b0, diff};
	endfunction

	// freeze, offset and counter next values
	always_comb
	begin
		koff_next   = koff_reg;
		frzKoff_next = frzKoff_reg;
		frzNat_next = frzNat_reg;
		frzEst_next = frzEst_reg;
		cntN_next   = cntN_reg;
		natB1_next  = nativeClock[1];          // last bit 1, for fall detection
		estB1_next  = peerClockEstimate[1];
		if (trainSwitch)
			koff_next = koff_reg + HCW_KOFF_STEP;
		if (linkState == HCW_PSCAN && ownCodeSeen)
			frzNat_next = nativeClock[16:12];
		if (linkState == HCW_ISCAN && ownCodeSeen)
			frzNat_next = nativeClock[16:12];
		if (linkState == HCW_PAGE && slaveIdSeen)
		begin
			frzEst_next  = peerClockEstimate;
			frzKoff_next = koff_reg;
			cntN_next    = 5'h00;
		end
		case (linkState)
			HCW_PSCAN, HCW_ISCAN:
				cntN_next = 5'h00;
			HCW_SRSP:
				if (pageAck)
					cntN_next = 5'h00;
				else if (natFall)
					cntN_next = cntN_reg + 5'h01;
			HCW_MRSP:
				if (estFall)
					cntN_next = cntN_reg + 5'h01;
			HCW_IRSP:
				if (syncInfoSent)
					cntN_next = cntN_reg + 5'h01;
			default:
				cntN_next = cntN_next;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			koff_reg    <= HCW_KOFF_A;
			frzKoff_reg <= HCW_KOFF_A;
			frzNat_reg  <= 5'h00;
			frzEst_reg  <= 28'h0000000;
			cntN_reg    <= 5'h00;
			natB1_reg   <= 1'b0;
			estB1_reg   <= 1'b0;
		end
		else
		begin
			koff_reg    <= koff_next;
			frzKoff_reg <= frzKoff_next;
			frzNat_reg  <= frzNat_next;
			frzEst_reg  <= frzEst_next;
			cntN_reg    <= cntN_next;
			natB1_reg   <= natB1_next;
			estB1_reg   <= estB1_next;
		end
	end

	// address and clock selection per state
	always_comb
	begin
		case (linkState)
			HCW_PSCAN, HCW_SRSP:
				addr = ownAddress[27:0];
			HCW_ISCAN, HCW_INQ, HCW_IRSP:
				addr = {defaultClassIndicator, generalInquiryCode};
			HCW_CONN:
				addr = masterAddress[27:0];
			default:
				addr = ownAddress[27:0];  // page side: paged unit address via ownAddress
		endcase
		case (linkState)
			HCW_PAGE, HCW_MRSP:
				clkSel = peerClockEstimate;
			HCW_CONN:
				clkSel = masterClock;
			default:
				clkSel = nativeClock;
		endcase
	end

	// control word next values; counter only entered mod 32 or 16
	always_comb
	begin
		logic [4:0] px;
		px      = 5'h00;
		b_next  = addr[22:19];
		e_next  = {addr[13], addr[11], addr[9], addr[7], addr[5], addr[3], addr[1]};
		a_next  = addr[27:23];
		c_next  = {addr[8], addr[6], addr[4], addr[2], addr[0]};
		d_next  = addr[18:10];
		f_next  = 7'h00;
		y1_next = clkSel[1];
		y2_next = hop23 ? (clkSel[1] ? HCW_Y2_23 : 6'h00) : (clkSel[1] ? HCW_Y2_79 : 6'h00);
		x_next  = 5'h00;
		case (linkState)
			HCW_PSCAN, HCW_ISCAN:
			begin
				x_next  = hop23 ? {1'b0, nativeClock[15:12]} : nativeClock[16:12];
				y1_next = 1'b0;
				y2_next = 6'h00;
			end
			HCW_PAGE:
				x_next = page_x(peerClockEstimate, koff_reg, hop23);
			HCW_INQ:
				x_next = page_x(nativeClock, koff_reg, hop23);
			HCW_SRSP, HCW_IRSP:
				x_next = hop23 ? {1'b0, frzNat_reg[3:0] + cntN_reg[3:0]}
				               : frzNat_reg + cntN_reg;
			HCW_MRSP:
			begin
				px     = page_x(frzEst_reg, frzKoff_reg, hop23);
				x_next = hop23 ? {1'b0, px[3:0] + cntN_reg[3:0] + HCW_N_ONE[3:0]}
				               : px + cntN_reg + HCW_N_ONE;
			end
			HCW_CONN:
			begin
				x_next = hop23 ? {1'b0, masterClock[5:2]} : masterClock[6:2];
				a_next = addr[27:23] ^ masterClock[25:21];
				c_next = {addr[8], addr[6], addr[4], addr[2], addr[0]} ^ masterClock[20:16];
				d_next = addr[18:10] ^ masterClock[15:7];
				f_next = hop23 ? f23 : f79;
			end
			default:
				x_next = 5'h00;
		endcase
	end

	// registered control set presented to the kernel
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			hopX  <= 5'h00;
			hopY1 <= 1'b0;
			hopY2 <= 6'h00;
			hopA  <= 5'h00;
			hopB  <= 4'h0;
			hopC  <= 5'h00;
			hopD  <= 9'h000;
			hopE  <= 7'h00;
			hopF  <= 7'h00;
		end
		else
		begin
			hopX  <= x_next;
			hopY1 <= y1_next;
			hopY2 <= y2_next;
			hopA  <= a_next;
			hopB  <= b_next;
			hopC  <= c_next;
			hopD  <= d_next;
			hopE  <= e_next;
			hopF  <= f_next;
		end
	end

	scan_x_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_PSCAN && !hop23) |=> (hopX == $past(nativeClock[16:12]) && hopY2 == 6'h00))
		else $error("scan phase not from native clock");
	conn_a_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_CONN) |=> hopA == ($past(masterAddress[27:23]) ^ $past(masterClock[25:21])))
		else $error("connection A wrong");
	conn_f23_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_CONN && hop23) |=> hopF < 7'h17)
		else $error("23-hop F out of range");
	pscan_addr_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_PSCAN) |=> hopB == $past(ownAddress[22:19]))
		else $error("page scan address wrong");
	iscan_addr_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_ISCAN) |=> hopA[4:1] == $past(defaultClassIndicator))
		else $error("class nibble missing");
	train_step_a : assert property (@(posedge clock) disable iff (sys_rst)
		trainSwitch |=> koff_reg == $past(koff_reg) + HCW_KOFF_STEP)
		else $error("train offset step wrong");
	ack_clear_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_SRSP && pageAck) |=> cntN_reg == 5'h00)
		else $error("counter not cleared");
	irsp_hold_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_IRSP && !syncInfoSent) |=> $stable(cntN_reg))
		else $error("inquiry counter moved");

	// freeze and counter steps of the response phases, then the connection phase and F range
	frz_nat_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_PSCAN && ownCodeSeen)
			|=> frzNat_reg == $past(nativeClock[16:12]))
		else $error("native bits not frozen");
	srsp_x_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_SRSP && !hop23)
			|=> hopX == $past(frzNat_reg) + $past(cntN_reg))
		else $error("slave response phase wrong");
	srsp_step_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_SRSP && !pageAck && natFall)
			|=> cntN_reg == $past(cntN_reg) + 5'h01)
		else $error("slave counter did not step");
	mrsp_frz_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_PAGE && slaveIdSeen)
			|=> frzEst_reg == $past(peerClockEstimate)
			&& frzKoff_reg == $past(koff_reg) && cntN_reg == 5'h00)
		else $error("master response freeze wrong");
	mrsp_step_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_MRSP && estFall)
			|=> cntN_reg == $past(cntN_reg) + 5'h01)
		else $error("master counter did not step");
	conn_x_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_CONN && !hop23) |=> hopX == $past(masterClock[6:2])
			&& hopY2 == ($past(masterClock[1]) ? HCW_Y2_79 : 6'h00))
		else $error("connection phase wrong");
	conn_f79_a : assert property (@(posedge clock) disable iff (sys_rst)
		(linkState == HCW_CONN && !hop23) |=> hopF < HCW_MOD79)
		else $error("79-hop F out of range");
endmodule
`default_nettype wire

// [sim/hcw_kernel_in.sv]
// Purpose: input stage of the hop selection kernel that takes the control set
// Assumes: the kernel samples the whole set once per slot
// Notes:   packed in kernel order X, Y1, Y2, A, B, C, D, E, F
`timescale 1ns/1ns
`default_nettype none
module hcw_kernel_in (
	input  wire logic [4:0] hopX,
	input  wire logic       hopY1,
	input  wire logic [5:0] hopY2,
	input  wire logic [4:0] hopA,
	input  wire logic [3:0] hopB,
	input  wire logic [4:0] hopC,
	input  wire logic [8:0] hopD,
	input  wire logic [6:0] hopE,
	input  wire logic [6:0] hopF,
	output logic [48:0]     ctrlWord
);
	// one word, so a half-updated set would show as a mismatch of the whole
	assign ctrlWord = {hopX, hopY1, hopY2, hopA, hopB, hopC, hopD, hopE, hopF};
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: self-checking bench for the hop control word generator
// Assumes: answer one cycle after the inputs; events are one-cycle pulses
// Notes:   event edges are not compared, only the settled cycle after them
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import hcw_pkg::*;
	logic        clock, sys_rst, h, ts, oc, pa, sd, si, hY1;
	hcw_state_e  st;
	logic [27:0] nc, pe, mc, fe;
	logic [47:0] oa, ma;
	logic [23:0] gc;
	logic [3:0]  dc, hB;
	logic [4:0]  ko, fk, fz, n, hX, hA, hC;
	logic [5:0]  hY2;
	logic [8:0]  hD;
	logic [6:0]  hE, hF;
	logic [48:0] word;
	logic [48:0] q[$];
	int          seed, errCount, checksDone, i, j;
	hcw_state_e  sl[5] = '{HCW_PSCAN, HCW_ISCAN, HCW_PAGE, HCW_INQ, HCW_CONN};

	// free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	hcw_gen i_dut (.clock(clock), .sys_rst(sys_rst), .linkState(st), .hop23(h),
		.nativeClock(nc), .peerClockEstimate(pe), .masterClock(mc), .ownAddress(oa),
		.masterAddress(ma), .generalInquiryCode(gc), .defaultClassIndicator(dc),
		.trainSwitch(ts), .ownCodeSeen(oc), .pageAck(pa), .slaveIdSeen(sd),
		.syncInfoSent(si), .hopX(hX), .hopY1(hY1), .hopY2(hY2), .hopA(hA), .hopB(hB),
		.hopC(hC), .hopD(hD), .hopE(hE), .hopF(hF));

	hcw_kernel_in i_kern (.hopX(hX), .hopY1(hY1), .hopY2(hY2), .hopA(hA), .hopB(hB),
		.hopC(hC), .hopD(hD), .hopE(hE), .hopF(hF), .ctrlWord(word));

	// page formula; the 23-hop form ignores the train offset
	function automatic logic [4:0] xp(input logic [27:0] c, input logic [4:0] o);
		if (h)
			return {1'b0, 4'(c[15:12] + 4'h8 + {c[4:2], c[0]})};
		return 5'(c[16:12] + o + 5'(4'({c[4:2], c[0]} - c[15:12])));
	endfunction

	// expected control set from the bench's own copy of inputs and state
	function automatic logic [48:0] wd();
		logic [27:0] a;
		logic [27:0] k;
		logic [4:0]  x;
		logic [6:0]  f;
		logic        y;
		k = (st == HCW_CONN) ? mc : 28'h0;
		a = (st == HCW_CONN) ? ma[27:0] :
			(st inside {HCW_ISCAN, HCW_INQ, HCW_IRSP}) ? {dc, gc} : oa[27:0];
		y = (st inside {HCW_PAGE, HCW_MRSP}) ? pe[1] : (st == HCW_CONN) ? mc[1] : nc[1];
		if (st inside {HCW_PSCAN, HCW_ISCAN})
			y = 1'b0;
		case (st)
			HCW_PSCAN, HCW_ISCAN: x = nc[16:12];
			HCW_PAGE: x = xp(pe, ko);
			HCW_INQ:  x = xp(nc, ko);
			HCW_MRSP: x = xp(fe, fk) + n + 5'h01;
			HCW_CONN: x = mc[6:2];
			default:  x = fz + n;
		endcase
		if (h)
			x[4] = 1'b0;
		f = (st != HCW_CONN) ? 7'h0 : h ? 7'({mc[27:6], 3'h0} % HCW_MOD23) :
			7'({mc[27:7], 4'h0} % HCW_MOD79);
		return {x, y, y ? (h ? 6'h10 : 6'h20) : 6'h00, a[27:23] ^ k[25:21], a[22:19],
			{a[8], a[6], a[4], a[2], a[0]} ^ k[20:16], a[18:10] ^ k[15:7],
			{a[13], a[11], a[9], a[7], a[5], a[3], a[1]}, f};
	endfunction

	// one edge; a checked cycle notes what the next answer must be
	task automatic cyc(input logic chk);
		@(posedge clock);
		if (chk)
			q.push_back(wd());
	endtask

	task automatic cmp(input logic [48:0] e, input logic [48:0] g);
		checksDone++;
		if (g !== e)
		begin
			errCount++;
			$display("Error at %0t expected %h got %h", $time, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// freeze native bits in a scan state, then acknowledge to clear the count
	task automatic frz(input hcw_state_e s);
		st <= s;
		nc <= 28'($random(seed)) | 28'h2;
		oc <= 1'b1;
		cyc(1'b0);
		oc <= 1'b0;
		fz = nc[16:12];
		st <= HCW_SRSP;
		pa <= 1'b1;
		cyc(1'b0);
		pa <= 1'b0;
		n = 5'h0;
	endtask

	// the answer to a checked cycle is settled by the falling edge after it
	always @(negedge clock)
		if (q.size() > 0)
			cmp(q.pop_front(), word);

	// a hang ends the run with a mismatch counted
	initial
	begin
		repeat (2000) @(posedge clock);
		errCount++;
		results();
	end

	initial
	begin
		seed = 86721;
		errCount = 0;
		checksDone = 0;
		{sys_rst, h, ts, oc, pa, sd, si} = 7'h40;
		{nc, pe, mc, fe, oa, ma, gc, dc, fk, fz, n} = '0;
		st = HCW_PSCAN;
		ko = HCW_KOFF_A;
		repeat (10) cyc(1'b0);
		sys_rst <= 1'b0;
		cyc(1'b1);
		// back-to-back random states, clocks and addresses
		for (i = 0; i < 60; i++)
		begin
			st <= sl[$unsigned($random(seed)) % 5];
			h <= 1'($random(seed));
			nc <= 28'($random(seed));
			pe <= 28'($random(seed));
			mc <= 28'($random(seed));
			oa <= 48'({$random(seed), $random(seed)});
			ma <= 48'({$random(seed), $random(seed)});
			gc <= 24'($random(seed));
			dc <= 4'($random(seed));
			cyc(1'b1);
		end
		$display("test random states done");
		h <= 1'b0;
		for (i = 0; i < 3; i++)
		begin
			st <= i[0] ? HCW_INQ : HCW_PAGE;
			ts <= 1'b1;
			cyc(1'b0);
			ts <= 1'b0;
			ko = ko + HCW_KOFF_STEP;
			cyc(1'b0);
			cyc(1'b1);
		end
		$display("test train switch done");
		for (j = 0; j < 2; j++)
		begin
			h <= j[0];
			frz(HCW_PSCAN);
			cyc(1'b1);
			for (i = 0; i < 3; i++)
			begin
				nc <= 28'($random(seed)) & ~28'h2;
				si <= 1'b1;
				cyc(1'b0);
				si <= 1'b0;
				n = n + 5'h1;
				cyc(1'b1);
				nc <= nc | 28'h2;
				cyc(1'b0);
			end
			st <= HCW_PAGE;
			pe <= 28'($random(seed)) | 28'h2;
			sd <= 1'b1;
			cyc(1'b0);
			sd <= 1'b0;
			fe = pe;
			fk = ko;
			n = 5'h0;
			st <= HCW_MRSP;
			pe <= 28'($random(seed)) | 28'h2;
			cyc(1'b0);
			cyc(1'b1);
			for (i = 0; i < 2; i++)
			begin
				pe <= 28'($random(seed)) & ~28'h2;
				cyc(1'b0);
				n = n + 5'h1;
				cyc(1'b1);
				pe <= pe | 28'h2;
				cyc(1'b0);
			end
			frz(HCW_ISCAN);
			st <= HCW_IRSP;
			cyc(1'b0);
			for (i = 0; i < 2; i++)
			begin
				nc <= 28'($random(seed)) & ~28'h2;
				cyc(1'b0);
				cyc(1'b1);
				si <= 1'b1;
				cyc(1'b0);
				si <= 1'b0;
				n = n + 5'h1;
				cyc(1'b1);
				nc <= nc | 28'h2;
				cyc(1'b0);
			end
			$display("test responses pass %0d done", j);
		end
		results();
	end
endmodule
`default_nettype wire
